// file: core/capbd_pkg.sv
// Purpose: Shared constants and types of the capacitive button detector.
// Assumes: 20 MHz reference clock, 32-bit classic Wishbone register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package capbd_pkg;

    // Geometry
    localparam int NUM_CH = 12;
    localparam int CH_W = 4;
    localparam int DCV_W = 16;
    localparam int TICK_W = 16;
    localparam int SENS_W = 4;
    localparam int AVE_SHIFT = 3;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ENABLE = 8'h04;
    localparam logic [7:0] REG_THRESH = 8'h08;
    localparam logic [7:0] REG_NOISE = 8'h0c;
    localparam logic [7:0] REG_PERIOD = 8'h10;
    localparam logic [7:0] REG_SENS_LO = 8'h14;
    localparam logic [7:0] REG_SENS_HI = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;

    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_COMP_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int STAT_COMP_BIT = 12;
    localparam int STAT_IRQ_BIT = 13;

    // Operating modes
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_ACTIVE = 2'h1;
    localparam logic [1:0] MODE_DOZE = 2'h2;

    // Built-in default parameter set: eight buttons
    localparam logic [11:0] DEF_ENABLE = 12'h0ff;
    localparam logic [11:0] DEF_PROX = 12'h000;
    localparam logic [15:0] DEF_THRESH = 16'h00a0;
    localparam logic [15:0] DEF_HYST = 16'h0010;
    localparam logic [15:0] DEF_NOISE_POS = 16'h0040;
    localparam logic [15:0] DEF_NOISE_NEG = 16'h0040;
    localparam logic [7:0] DEF_PER_ACT = 8'h1e;
    localparam logic [7:0] DEF_PER_DOZE = 8'hc3;
    localparam logic [15:0] DEF_COMP_INT = 16'h0000;
    localparam logic [SENS_W-1:0] DEF_SENS = 4'h8;
    localparam logic [1:0] DEF_MODE = MODE_ACTIVE;

    typedef enum logic [2:0] {
        ST_LOAD, ST_WAIT, ST_CONV, ST_WAITC, ST_PROC, ST_END
    } capbd_state_type;

    // Request to the charge converter
    typedef struct packed {
        logic start;
        logic [CH_W-1:0] chan;
        logic [SENS_W-1:0] reps;
        logic [DCV_W-1:0] comp;
    } capbd_conv_req_type;

    // Answer from the charge converter
    typedef struct packed {
        logic done;
        logic signed [TICK_W-1:0] ticks;
    } capbd_conv_rsp_type;

    // Stored parameter image offered at power-up
    typedef struct packed {
        logic valid;
        logic [11:0] enable;
        logic [11:0] prox;
        logic [15:0] thresh;
        logic [15:0] hyst;
    } capbd_nvm_type;

endpackage

// file: core/capbd_top.sv
// Purpose: Scan, compensation and button decision for twelve sense inputs.
// Assumes: Converter answers each start with one done pulse; inputs sync.
// Notes: Registers answer over classic Wishbone with one wait state.
`timescale 1ns/1ps

// Operation
// - Each input is ON or OFF; proximity inputs use same logic, more sensitive.
// - OFF to ON when value reaches threshold plus hysteresis.
// - ON to OFF when value falls below threshold minus hysteresis, or at compensation end.
// - Store one input's ticks, then convert the next until all done.
// - Disabled inputs are skipped entirely in the scan.
// - Each conversion repeats charge transfer a configurable number of times.
// - The repeat count is set per input.
// - Keep a 16-bit compensation value per input, applied each conversion.
// - At power-up compensate every enabled input toward zero ticks and keep values.
// - Compensation values are volatile and rebuilt after every reset.
// - Average outside positive or negative noise band starts compensation.
// - Optional periodic compensation at a set scan interval.
// - Host may request compensation only in active or doze mode.
// - Raw ticks first pass a low-pass filter giving an average.
// - Difference value is raw ticks minus filtered average.
// - Difference, average and parameters drive button state and status.
// - Without stored parameters start with built-in eight-button defaults.
// - Twelve sense inputs, index zero to eleven.
// - Enabled inputs are converted in ascending index order.
// - At power-up copy valid stored parameters, else the defaults.
// - Raise host interrupt when a compensation procedure completes.
module capbd_top #(
    parameter int P_CYC_PER_MS = capbd_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Charge converter
    output capbd_pkg::capbd_conv_req_type CONV_REQ_O,
    input wire capbd_pkg::capbd_conv_rsp_type CONV_RSP_I,
    // Stored parameters
    input wire capbd_pkg::capbd_nvm_type NVM_I,
    // Results
    output logic [11:0] BUTTON_STATE_O,
    output logic HOST_IRQ_LINE_O
);
    import capbd_pkg::*;

    typedef struct packed {
        capbd_state_type state;
        logic [CH_W-1:0] ch;
        logic [3:0] bitn;
        logic comp_run;
        logic comp_pend;
        logic [15:0] ms_cnt;
        logic [7:0] per_cnt;
        logic [15:0] scan_cnt;
        logic signed [TICK_W-1:0] ticks;
        logic run;
        logic [1:0] mode;
        logic [11:0] enable;
        logic [11:0] prox;
        logic [15:0] thresh;
        logic [15:0] hyst;
        logic [15:0] npos;
        logic [15:0] nneg;
        logic [7:0] per_act;
        logic [7:0] per_doze;
        logic [15:0] comp_int;
        logic [NUM_CH-1:0][SENS_W-1:0] sens;
        logic [NUM_CH-1:0][DCV_W-1:0] comp_value;
        logic [NUM_CH-1:0][TICK_W-1:0] ave;
        logic [11:0] btn;
        logic irq;
        logic ack;
        logic [31:0] rdat;
        capbd_conv_req_type req;
    } capbd_regs_type;

    capbd_regs_type r, n;

    // Lowest enabled input at or above a start index
    function automatic logic [4:0] find_ch(input logic [11:0] en,
                                           input logic [4:0] from);
        logic [4:0] res;
        res = 5'h1f;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (en[i] && (5'(i) >= from)) begin
                res = 5'(i);
            end
        end
        return res;
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    logic bus_req;
    logic ms_tick;
    logic [4:0] first_ch;
    logic [4:0] next_ch;
    logic signed [16:0] diff;
    logic signed [16:0] on_lvl;
    logic signed [16:0] off_lvl;
    logic signed [16:0] ave_new;
    logic [15:0] thr_eff;

    assign bus_req = WB_CYC_I && WB_STB_I && !r.ack;
    assign ms_tick = (r.ms_cnt == 16'(P_CYC_PER_MS - 1));
    assign first_ch = find_ch(r.enable, 5'h00);
    assign next_ch = find_ch(r.enable, 5'(r.ch) + 5'h01);
    // Raw minus average is the fast change
    assign diff = 17'(signed'(r.ticks)) - 17'(signed'(r.ave[r.ch]));
    // Proximity inputs detect at half the touch threshold
    assign thr_eff = r.prox[r.ch] ? (r.thresh >> 1) : r.thresh;
    assign on_lvl = 17'(thr_eff) + 17'(r.hyst);
    assign off_lvl = 17'(thr_eff) - 17'(r.hyst);
    // One-pole low-pass filter on raw ticks
    assign ave_new = 17'(signed'(r.ave[r.ch])) + (diff >>> AVE_SHIFT);

    // Next-state logic for bus, scan and compensation
    always_comb begin
        n = r;
        n.req.start = 1'b0;
        n.ack = 1'b0;
        n.ms_cnt = ms_tick ? 16'h0000 : r.ms_cnt + 16'h0001;

        // Register reads and writes, taken one cycle before ack
        if (bus_req) begin
            n.ack = 1'b1;
            n.rdat = 32'h0000_0000;
            unique case (WB_ADR_I)
                REG_CTRL: begin
                    n.rdat = {28'h0000000, r.mode, r.comp_pend, r.run};
                end
                REG_ENABLE: n.rdat = {8'h00, r.prox, r.enable};
                REG_THRESH: n.rdat = {r.hyst, r.thresh};
                REG_NOISE: n.rdat = {r.nneg, r.npos};
                REG_PERIOD: n.rdat = {r.comp_int, r.per_doze, r.per_act};
                REG_SENS_LO: n.rdat = r.sens[7:0];
                REG_SENS_HI: n.rdat = {16'h0000, r.sens[11:8]};
                REG_STATUS: begin
                    n.rdat = {18'h00000, r.irq, r.comp_run, r.btn};
                    if (!WB_WE_I) begin
                        n.irq = 1'b0;
                    end
                end
                default: n.rdat = 32'h0000_0000;
            endcase
            if (WB_WE_I) begin
                unique case (WB_ADR_I)
                    REG_CTRL: begin
                        if (WB_SEL_I[0]) begin
                            n.run = WB_DAT_I[CTRL_RUN_BIT];
                            n.mode = WB_DAT_I[CTRL_MODE_LSB +: 2];
                            // Host request honoured in active or doze only
                            if (WB_DAT_I[CTRL_COMP_BIT] &&
                                (r.mode == MODE_ACTIVE ||
                                 r.mode == MODE_DOZE)) begin
                                n.comp_pend = 1'b1;
                            end
                        end
                    end
                    REG_ENABLE: begin
                        {n.prox, n.enable} = 24'(merge({8'h00, r.prox,
                            r.enable}, WB_DAT_I, WB_SEL_I));
                    end
                    REG_THRESH: begin
                        {n.hyst, n.thresh} = merge({r.hyst, r.thresh},
                            WB_DAT_I, WB_SEL_I);
                    end
                    REG_NOISE: begin
                        {n.nneg, n.npos} = merge({r.nneg, r.npos},
                            WB_DAT_I, WB_SEL_I);
                    end
                    REG_PERIOD: begin
                        {n.comp_int, n.per_doze, n.per_act} = merge(
                            {r.comp_int, r.per_doze, r.per_act},
                            WB_DAT_I, WB_SEL_I);
                    end
                    REG_SENS_LO: begin
                        n.sens[7:0] = merge(r.sens[7:0], WB_DAT_I,
                            WB_SEL_I);
                    end
                    REG_SENS_HI: begin
                        n.sens[11:8] = 16'(merge({16'h0000, r.sens[11:8]},
                            WB_DAT_I, WB_SEL_I));
                    end
                    default: ;
                endcase
            end
        end

        // Scan sequencer
        unique case (r.state)
            ST_LOAD: begin
                // Stored image if valid, else built-in defaults
                n.enable = NVM_I.valid ? NVM_I.enable : DEF_ENABLE;
                n.prox = NVM_I.valid ? NVM_I.prox : DEF_PROX;
                n.thresh = NVM_I.valid ? NVM_I.thresh : DEF_THRESH;
                n.hyst = NVM_I.valid ? NVM_I.hyst : DEF_HYST;
                n.comp_pend = 1'b1;
                n.per_cnt = 8'h00;
                n.state = ST_WAIT;
            end
            ST_WAIT: begin
                if (ms_tick && r.per_cnt != 8'h00) begin
                    n.per_cnt = r.per_cnt - 8'h01;
                end
                if (r.per_cnt == 8'h00 && r.run && r.mode != MODE_SLEEP &&
                    first_ch != 5'h1f) begin
                    n.ch = first_ch[CH_W-1:0];
                    if (r.comp_pend && !r.comp_run) begin
                        n.comp_run = 1'b1;
                        n.bitn = 4'hf;
                        n.comp_value = '0; // Rebuilt from scratch
                    end
                    n.state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (r.enable[r.ch]) begin
                    // Trial value sets the bit under test
                    n.req.start = 1'b1;
                    n.req.chan = r.ch;
                    n.req.reps = r.sens[r.ch];
                    n.req.comp = r.comp_run ?
                        (r.comp_value[r.ch] | (16'h0001 << r.bitn)) : r.comp_value[r.ch];
                    n.state = ST_WAITC;
                end else if (next_ch == 5'h1f) begin
                    // Input disabled after it was picked
                    n.state = ST_END;
                end else begin
                    n.ch = next_ch[CH_W-1:0];
                end
            end
            ST_WAITC: begin
                if (CONV_RSP_I.done) begin
                    n.ticks = CONV_RSP_I.ticks;
                    n.state = ST_PROC;
                end
            end
            ST_PROC: begin
                if (r.comp_run) begin
                    // Positive ticks: DAC still short, keep the bit
                    if (r.ticks > 16'sh0000) begin
                        n.comp_value[r.ch] = r.req.comp;
                    end
                end else begin
                    n.ave[r.ch] = ave_new[15:0];
                    if (!r.btn[r.ch] && diff >= on_lvl) begin
                        n.btn[r.ch] = 1'b1;
                        n.irq = 1'b1;
                    end else if (r.btn[r.ch] && diff < off_lvl) begin
                        n.btn[r.ch] = 1'b0;
                        n.irq = 1'b1;
                    end
                    // Drift beyond the noise band asks for compensation
                    // Signed compare: a negative average must not wrap
                    if (ave_new > signed'(17'(r.npos)) ||
                        ave_new < -signed'(17'(r.nneg))) begin
                        n.comp_pend = 1'b1;
                    end
                end
                if (next_ch == 5'h1f) begin
                    n.state = ST_END;
                end else begin
                    n.ch = next_ch[CH_W-1:0];
                    n.state = ST_CONV;
                end
            end
            ST_END: begin
                if (r.comp_run && r.bitn != 4'h0) begin
                    // Next bit of the search over all enabled inputs
                    n.bitn = r.bitn - 4'h1;
                    n.ch = first_ch[CH_W-1:0];
                    n.state = ST_CONV;
                end else begin
                    if (r.comp_run) begin
                        n.comp_run = 1'b0;
                        n.comp_pend = 1'b0;
                        n.ave = '0;
                        n.btn = 12'h000;
                        n.irq = 1'b1;
                        n.scan_cnt = 16'h0000;
                    end else begin
                        n.scan_cnt = r.scan_cnt + 16'h0001;
                        if (r.comp_int != 16'h0000 &&
                            r.scan_cnt + 16'h0001 >= r.comp_int) begin
                            n.comp_pend = 1'b1;
                        end
                    end
                    n.per_cnt = (r.mode == MODE_DOZE) ? r.per_doze :
                        r.per_act;
                    n.state = ST_WAIT;
                end
            end
        endcase
    end

    // State register; compensation values clear on every reset
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            r <= '0;
            r.state <= ST_LOAD;
            r.run <= 1'b1;
            r.mode <= DEF_MODE;
            r.npos <= DEF_NOISE_POS;
            r.nneg <= DEF_NOISE_NEG;
            r.per_act <= DEF_PER_ACT;
            r.per_doze <= DEF_PER_DOZE;
            r.comp_int <= DEF_COMP_INT;
            r.sens <= {NUM_CH{DEF_SENS}};
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flip-flops
    assign WB_DAT_O = r.rdat;
    assign WB_ACK_O = r.ack;
    assign CONV_REQ_O = r.req;
    assign BUTTON_STATE_O = r.btn;
    assign HOST_IRQ_LINE_O = r.irq;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);

    sequence conv_issued;
        r.state == ST_CONV && r.enable[r.ch];
    endsequence

    sequence conv_pulse;
        CONV_REQ_O.start && CONV_REQ_O.chan == $past(r.ch);
    endsequence

    chk_conv_start_chan: assert property (
        conv_issued |=> conv_pulse)
        else $error("conversion start missing or wrong input");
    chk_skip_disabled: assert property (
        CONV_REQ_O.start |-> $past(r.enable[r.ch]))
        else $error("disabled input converted");
    chk_reps_per_input: assert property (
        CONV_REQ_O.start |-> CONV_REQ_O.reps == $past(r.sens[r.ch]))
        else $error("repeat count not taken from the input");
    chk_order_ascend: assert property (
        (r.state == ST_PROC && next_ch != 5'h1f) |=> r.ch > $past(r.ch))
        else $error("inputs not scanned in ascending order");
    chk_btn_on: assert property (
        (r.state == ST_PROC && !r.comp_run && !r.btn[r.ch] &&
         diff >= on_lvl) |=> BUTTON_STATE_O[$past(r.ch)])
        else $error("button did not turn on");
    chk_btn_hold: assert property (
        (r.state == ST_PROC && !r.comp_run && r.btn[r.ch] &&
         diff >= off_lvl) |=> BUTTON_STATE_O[$past(r.ch)])
        else $error("button released inside hysteresis");
    chk_comp_irq: assert property (
        $fell(r.comp_run) |-> HOST_IRQ_LINE_O && r.ave == '0)
        else $error("compensation end without irq or average reset");
    chk_host_sleep: assert property (
        (bus_req && WB_WE_I && WB_ADR_I == REG_CTRL && WB_SEL_I[0] &&
         WB_DAT_I[CTRL_COMP_BIT] && r.mode == MODE_SLEEP &&
         !r.comp_pend && r.state == ST_WAIT) |=> !r.comp_pend)
        else $error("compensation accepted in sleep");
    chk_powerup_comp: assert property (
        $fell(RESET_I) |-> ##[1:3] r.comp_pend)
        else $error("no compensation requested after reset");
    chk_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");

endmodule // capbd_top

// file: verification/capbd_conv_model.sv
// Purpose: Behavioural charge converter with one sense cap per input.
// Assumes: One conversion at a time, started by a one-cycle pulse.
// Notes: Ticks are cap minus comp plus touch; idle ticks are inverted.
`timescale 1ns/1ps
module capbd_conv_model
    import capbd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Converter link
    input wire capbd_conv_req_type req_i,
    output capbd_conv_rsp_type rsp_o
);
    logic signed [TICK_W-1:0] cap [NUM_CH];
    logic signed [TICK_W-1:0] touch [NUM_CH];
    logic [DCV_W-1:0] comp_seen [NUM_CH];
    logic [CH_W-1:0] chan_r;
    logic [DCV_W-1:0] comp_r;
    int wait_r;

    // Answer after 1 to 3 cycles; stale ticks toggle so none is trusted
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_r <= 0;
            rsp_o <= '0;
        end else begin
            rsp_o.done <= 1'b0;
            rsp_o.ticks <= ~rsp_o.ticks;
            if (req_i.start) begin
                chan_r <= req_i.chan;
                comp_r <= req_i.comp;
                comp_seen[req_i.chan] <= req_i.comp;
                wait_r <= 1 + int'(req_i.chan % 3);
            end else if (wait_r == 1) begin
                rsp_o.done <= 1'b1;
                rsp_o.ticks <= cap[chan_r] - $signed(comp_r) + touch[chan_r];
                wait_r <= 0;
            end else if (wait_r > 1) begin
                wait_r <= wait_r - 1;
            end
        end
    end
endmodule // capbd_conv_model

// file: verification/tb_cap_button_detect_comp.sv
// Purpose: Self-checking bench for the capacitive button detector.
// Assumes: Short millisecond count so scans take a few hundred cycles.
// Notes: Converter model answers every start; bench speaks Wishbone.
`timescale 1ns/1ps
module tb_cap_button_detect_comp;
    import capbd_pkg::*;
    localparam int CPM = 4;
    logic clk, rst, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [11:0] btn;
    capbd_conv_req_type req;
    capbd_conv_rsp_type rsp;
    capbd_nvm_type nvm;
    logic [7:0] log_q [$];
    int n_c0, n_mismatch, compares;

    capbd_top #(.P_CYC_PER_MS(CPM)) DUT (.REF_CLK_I(clk), .RESET_I(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CONV_REQ_O(req), .CONV_RSP_I(rsp), .NVM_I(nvm),
        .BUTTON_STATE_O(btn), .HOST_IRQ_LINE_O(irq));
    capbd_conv_model PART (.clk_i(clk), .rst_i(rst), .req_i(req),
        .rsp_o(rsp));

    // Clock of 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Log every conversion start as {channel, repeats}
    always @(posedge clk) begin
        if (req.start === 1'b1) begin
            log_q.push_back({req.chan, req.reps});
            if (req.chan == 0) n_c0++;
        end
    end

    task automatic complete_run();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One classic cycle; held until ack is sampled, then released
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) n_mismatch++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // Returns on the negedge after the next scan starts at input zero
    task automatic wait_c0();
        int k, n;
        k = n_c0;
        n = 0;
        while (n_c0 == k && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) n_mismatch++;
        @(negedge clk);
    endtask

    // Compensation end: irq rises, status shows it, read clears it
    task automatic comp_done();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) n_mismatch++;
        rd_chk(REG_STATUS, 32'h2000);
        @(negedge clk);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_boot();
        logic [31:0] q;
        rd_chk(REG_ENABLE, 32'h0ff);
        rd_chk(REG_THRESH, {DEF_HYST, DEF_THRESH});
        wb(1'b0, REG_STATUS, 32'h0, q);
        chk(32'(q[STAT_COMP_BIT]), 32'h1);
        rd_chk(8'h40, 32'h0);
        comp_done();
        wait_c0();
        wait_c0();
        for (int i = 0; i < 8; i++) chk(PART.comp_seen[i], PART.cap[i] - 1);
    endtask

    task automatic t_scan();
        logic [7:0] e [5] = '{8'h23, 8'h56, 8'h78, 8'hbf, 8'h01};
        wr(REG_NOISE, 32'h7fff7fff);
        wr(REG_SENS_LO, 32'h87654321);
        wr(REG_SENS_HI, 32'h0000f000);
        wr(REG_ENABLE, 32'h8a5);
        wait_c0();
        wait_c0();
        log_q.delete();
        wait_c0();
        chk(log_q.size(), 5);
        for (int i = 0; i < 5; i++) chk(log_q[i], e[i]);
    endtask

    task automatic t_touch();
        logic [15:0] d [4];
        logic [15:0] ave;
        logic on [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        d = '{DEF_THRESH + DEF_HYST - 1, DEF_THRESH + DEF_HYST,
              DEF_THRESH - DEF_HYST, DEF_THRESH - DEF_HYST - 1};
        ave = 16'h0;
        for (int i = 0; i < 4; i++) begin
            PART.touch[2] = d[i] + ave - 1;
            ave = ave + (d[i] >>> 3);
            wait_c0();
            chk(btn, {9'h0, on[i], 2'h0});
            rd_chk(REG_STATUS, {18'h0, on[i] != (i > 0 && on[i-1]),
                   10'h0, on[i], 2'h0});
        end
        PART.touch[2] = 16'h0;
    endtask

    task automatic t_host();
        wr(REG_CTRL, 32'h01);
        wr(REG_CTRL, 32'h03);
        rd_chk(REG_CTRL, 32'h01);
        rd_chk(REG_STATUS, 32'h0);
        wr(REG_CTRL, 32'h09);
        wr(REG_CTRL, 32'h0b);
        comp_done();
        wr(REG_CTRL, 32'h05);
        // Proximity on input 2 detects at half threshold plus hysteresis
        wr(REG_ENABLE, 32'h48a5);
        wait_c0();
        PART.touch[2] = 16'h005f;
        wait_c0();
        chk(btn, 32'h004);
        rd_chk(REG_STATUS, 32'h2004);
        PART.touch[2] = 16'h0;
        wait_c0();
        rd_chk(REG_STATUS, 32'h2000);
        wr(REG_ENABLE, 32'h08a5);
    endtask

    task automatic t_auto();
        wr(REG_NOISE, 32'h00400040);
        PART.touch[0] = 16'h0050;
        comp_done();
        wait_c0();
        wait_c0();
        chk(PART.comp_seen[0], PART.cap[0] + 16'h004f);
        wr(REG_NOISE, 32'h7fff7fff);
        wr(REG_PERIOD, 32'h0003c31e);
        comp_done();
        wr(REG_PERIOD, 32'h0000c31e);
    endtask

    task automatic t_nvm();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        nvm <= '{1'b1, 12'h00f, 12'h000, 16'h0050, 16'h0008};
        PART.cap[0] = 16'h0800;
        PART.touch[0] = 16'h0;
        rst <= 1'b0;
        rd_chk(REG_ENABLE, 32'h00f);
        rd_chk(REG_THRESH, 32'h00080050);
        comp_done();
        wait_c0();
        wait_c0();
        chk(PART.comp_seen[0], 16'h07ff);
    endtask

    // Watchdog
    initial begin
        #(60000 * 50);
        n_mismatch++;
        complete_run();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'hf;
        nvm = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            PART.cap[i] = (i < 8) ? 16'(16'h0100 + i * 16'h0111) : 16'h0;
            PART.touch[i] = 16'h0;
        end
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_scan();
        t_touch();
        t_host();
        t_auto();
        t_nvm();
        complete_run();
    end
endmodule // tb_cap_button_detect_comp
